// *** verif/cse_checker.sv ***
// Port-level assertions for the compare-and-skip execution block
module cse_checker (
    // Clock and control
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Instruction side
    input wire cse_pkg::cse_instr_s instrIn,
    input wire logic [cse_pkg::WORDS_W-1:0] nextWords,
    input wire logic [cse_pkg::DATA_W-1:0] workingReg,
    // Memory and sequencing
    input wire cse_pkg::cse_mem_rd_s memRd,
    input wire logic [cse_pkg::DATA_W-1:0] memRdData,
    input wire cse_pkg::cse_mem_wr_s memWr,
    input wire cse_pkg::cse_working_register_wr_s wregWr,
    input wire logic [1:0] qPhase,
    input wire logic busy,
    input wire logic nopActive,
    input wire logic discardFetch,
    input wire logic pcSkipStrobe,
    input wire logic [cse_pkg::WORDS_W-1:0] pcSkipWords
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic q1, isEq, isGt, isCpl;
    logic [4:0] nopRun, skipLen;
    assign q1 = qPhase == 2'h0 && clkEn && instrIn.valid && !nopActive;
    assign isEq = q1 && instrIn.word[15:9] == cse_pkg::OPC_CMP_EQ;
    assign isGt = q1 && instrIn.word[15:9] == cse_pkg::OPC_CMP_GT;
    assign isCpl = q1 && instrIn.word[15:10] == cse_pkg::OPC_COMPL;
    // Length of the current run of skip cycles
    always_ff @(posedge sys_clk) begin
        if (rst || !nopActive) nopRun <= 5'h00;
        else nopRun <= nopRun + 5'h01;
    end
    always_ff @(posedge sys_clk) begin
        if (rst) skipLen <= 5'h00;
        else if (discardFetch) skipLen <= {1'b0, pcSkipWords, 2'h0};
    end
    property p_eq; isEq |-> ##4 discardFetch == ($past(memRdData, 3) == $past(workingReg, 2)); endproperty
    a_eq: assert property (p_eq) else $error("equal compare skip wrong");
    property p_gt; isGt |-> ##4 discardFetch == ($past(memRdData, 3) > $past(workingReg, 2)); endproperty
    a_gt: assert property (p_gt) else $error("greater compare skip wrong");
    property p_cplw; isCpl && !instrIn.word[9] |-> ##3 wregWr.en && wregWr.data == ~$past(memRdData, 2); endproperty
    a_cplw: assert property (p_cplw) else $error("complement to working register wrong");
    property p_cplf; isCpl && instrIn.word[9] |-> ##3 memWr.en && !wregWr.en && memWr.data == ~$past(memRdData, 2);
    endproperty
    a_cplf: assert property (p_cplf) else $error("complement to file wrong");
    property p_busy; isEq || isGt || isCpl |=> memRd.en ##0 busy[*3] ##1 !busy; endproperty
    a_busy: assert property (p_busy) else $error("phase sequence wrong");
    property p_nowr; isEq || isGt |=> (!memWr.en && !wregWr.en)[*4]; endproperty
    a_nowr: assert property (p_nowr) else $error("compare wrote a result");
    property p_pair; discardFetch |-> pcSkipStrobe && pcSkipWords == $past(nextWords); endproperty
    a_pair: assert property (p_pair) else $error("skip word count wrong");
    property p_nop; $fell(nopActive) |-> nopRun == skipLen; endproperty
    a_nop: assert property (p_nop) else $error("skip cycle count wrong");
    property p_ign; qPhase == 2'h0 && !(isEq || isGt || isCpl) |=> !busy && !memRd.en; endproperty
    a_ign: assert property (p_ign) else $error("unhandled opcode executed");
    property p_idle; nopActive |-> !busy && !memRd.en && !memWr.en && !wregWr.en; endproperty
    a_idle: assert property (p_idle) else $error("skip cycle not idle");
    c_eq: cover property (isEq ##4 discardFetch);
    c_three: cover property (discardFetch && pcSkipWords == 2'h3);
    c_cpl: cover property (isCpl ##3 memWr.en);
endmodule

bind cse_core cse_checker chk_u (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .instrIn(instrIn),
    .nextWords(nextWords), .workingReg(workingReg), .memRd(memRd), .memRdData(memRdData), .memWr(memWr),
    .wregWr(wregWr), .qPhase(qPhase), .busy(busy), .nopActive(nopActive), .discardFetch(discardFetch),
    .pcSkipStrobe(pcSkipStrobe), .pcSkipWords(pcSkipWords));

// *** verif/cse_core_bench.sv ***
// Self-checking testbench for the compare-and-skip execution block
module cse_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    cse_pkg::cse_instr_s instrIn = '0;
    logic [1:0] nextWords = 2'h1;
    logic [7:0] workingReg = 8'h00;
    logic [3:0] bankSelect = 4'h0;
    logic extEnable = 1'b0;
    logic [11:0] indexBase = 12'h300;
    cse_pkg::cse_mem_rd_s memRd;
    cse_pkg::cse_mem_wr_s memWr;
    cse_pkg::cse_working_register_wr_s wregWr;
    logic [7:0] memRdData;
    logic [1:0] qPhase, pcSkipWords;
    logic busy, nopActive, discardFetch, pcSkipStrobe;
    int errors = 0;
    int numChecks = 0;
    always #5 sys_clk = ~sys_clk;
    cse_core dut_u (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .instrIn(instrIn), .nextWords(nextWords),
        .workingReg(workingReg), .bankSelect(bankSelect), .extEnable(extEnable), .indexBase(indexBase),
        .memRd(memRd), .memRdData(memRdData), .memWr(memWr), .wregWr(wregWr), .qPhase(qPhase), .busy(busy),
        .nopActive(nopActive), .discardFetch(discardFetch), .pcSkipStrobe(pcSkipStrobe), .pcSkipWords(pcSkipWords));
    cse_data_mem mem_u (.sys_clk(sys_clk), .memRd(memRd), .memWr(memWr), .memRdData(memRdData));

    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        numChecks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // One instruction from Q1 to the end of its skip cycles
    task automatic run(input logic [15:0] w, input logic [7:0] wv, input logic [7:0] dv, input logic [1:0] nw,
                       input logic [11:0] ea, input logic hit, input logic [3:0] bs, input logic ext);
        logic sk, cpl;
        int n;
        cpl = w[15:10] == cse_pkg::OPC_COMPL;
        sk = w[15:9] == cse_pkg::OPC_CMP_EQ ? dv == wv : w[15:9] == cse_pkg::OPC_CMP_GT && dv > wv;
        mem_u.mem[ea] = dv;
        do @(negedge sys_clk); while (qPhase !== 2'h3);
        @(posedge sys_clk);
        instrIn <= '{valid: 1'b1, word: w};
        workingReg <= wv;
        nextWords <= nw;
        bankSelect <= bs;
        extEnable <= ext;
        @(posedge sys_clk);
        instrIn.valid <= 1'b0;
        @(negedge sys_clk);
        check("busy", 12'(hit), 12'(busy));
        check("qPhase", 12'h001, 12'(qPhase));
        check("memRd.en", 12'(hit), 12'(memRd.en));
        if (hit) check("memRd.addr", ea, memRd.addr);
        repeat (2) @(negedge sys_clk);
        check("wregWr.en", 12'(cpl && !w[9]), 12'(wregWr.en));
        check("memWr.en", 12'(cpl && w[9]), 12'(memWr.en));
        if (cpl) check("result", {4'h0, ~dv}, {4'h0, w[9] ? memWr.data : wregWr.data});
        if (cpl && w[9]) check("memWr.addr", ea, memWr.addr);
        @(negedge sys_clk);
        check("discardFetch", 12'(sk), 12'(discardFetch));
        check("pcSkipStrobe", 12'(sk), 12'(pcSkipStrobe));
        if (sk) check("pcSkipWords", 12'(nw), 12'(pcSkipWords));
        n = 0;
        while (nopActive === 1'b1 && n < 20) begin
            n++;
            @(negedge sys_clk);
        end
        check("skip cycles", sk ? 12'(nw) * 12'h004 : 12'h000, 12'(n));
    endtask

    task automatic t_equal;
        run(16'h6280, 8'h3C, 8'h3C, 2'h1, 12'hF80, 1'b1, 4'h0, 1'b0);
        run(16'h6280, 8'h3C, 8'h3D, 2'h1, 12'hF80, 1'b1, 4'h0, 1'b0);
        $display("test equal done");
    endtask

    task automatic t_greater;
        run(16'h6512, 8'h10, 8'h11, 2'h2, 12'h512, 1'b1, 4'h5, 1'b0);
        run(16'h6512, 8'h11, 8'h11, 2'h3, 12'h512, 1'b1, 4'h5, 1'b0);
        run(16'h6412, 8'h00, 8'hFF, 2'h3, 12'h012, 1'b1, 4'h5, 1'b0);
        $display("test greater done");
    endtask

    task automatic t_ext;
        run(16'h625F, 8'h01, 8'h01, 2'h1, 12'h35F, 1'b1, 4'h5, 1'b1);
        run(16'h6260, 8'h01, 8'h02, 2'h1, 12'hF60, 1'b1, 4'h5, 1'b1);
        run(16'h635F, 8'h01, 8'h02, 2'h2, 12'h55F, 1'b1, 4'h5, 1'b1);
        $display("test indexed done");
    endtask

    task automatic t_compl;
        run(16'h1C20, 8'h00, 8'h13, 2'h1, 12'h020, 1'b1, 4'h5, 1'b0);
        run(16'h1F33, 8'h00, 8'hA5, 2'h1, 12'h533, 1'b1, 4'h5, 1'b0);
        run(16'h6080, 8'h05, 8'h01, 2'h1, 12'hF80, 1'b0, 4'h5, 1'b0);
        $display("test complement and unhandled done");
    endtask

    // Clock enable low for three edges must hold the phase
    task automatic t_freeze;
        do @(negedge sys_clk); while (qPhase !== 2'h1);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        clkEn <= 1'b1;
        @(negedge sys_clk);
        check("qPhase frozen", 12'h002, 12'(qPhase));
        $display("test freeze done");
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        t_equal();
        t_greater();
        t_ext();
        t_compl();
        t_freeze();
        print_verdict();
    end

    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule

// *** verif/cse_data_mem.sv ***
// Behavioural data memory with combinational read
module cse_data_mem (
    // Clock
    input wire logic sys_clk,
    // Access ports
    input wire cse_pkg::cse_mem_rd_s memRd,
    input wire cse_pkg::cse_mem_wr_s memWr,
    output logic [7:0] memRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    logic [7:0] last = 8'h00;
    // Unselected read returns a changing pattern, never the held byte
    always_comb memRdData = memRd.en ? mem[memRd.addr] : ~last;
    always @(posedge sys_clk) begin
        last <= memRdData;
        if (memWr.en) mem[memWr.addr] <= memWr.data;
    end
endmodule

// *** verilog/cse_core.sv ***
// Execution of compare-and-skip and complement-file instructions
//
// Function
// - Opcode upper byte 0110 001a is compare-skip-equal, a picks bank mode, low byte is address f.
// - Opcode upper byte 0110 010a is compare-skip-greater, a picks bank mode, low byte is address f.
// - Compare-equal subtracts working register from the byte unsigned, skips on a match, writes nothing.
// - Compare-greater subtracts unsigned and skips only when the byte exceeds working register, writes nothing.
// - A true skip discards the fetched next instruction and runs a no-operation cycle instead.
// - A skip over a two-word instruction adds two cycles, over a three-word instruction three cycles.
// - Compare cycles run decode, read, process, idle in Q1 to Q4 and every skip cycle idles all four phases.
// - Bit a clear uses the access bank, bit a set uses the bank select register.
// - With a clear and the extended set on, addresses up to 95 are indexed literal offsets.
// - Complement-file inverts the byte and writes it in Q4 to working register if d is 0, else back to f.
module cse_core (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Instruction and fetch pipeline
    input wire cse_pkg::cse_instr_s instrIn,
    input wire logic [cse_pkg::WORDS_W-1:0] nextWords,
    // Core state
    input wire logic [cse_pkg::DATA_W-1:0] workingReg,
    input wire logic [cse_pkg::BANK_W-1:0] bankSelect,
    input wire logic extEnable,
    input wire logic [cse_pkg::ADDR_W-1:0] indexBase,
    // Data memory
    output cse_pkg::cse_mem_rd_s memRd,
    input wire logic [cse_pkg::DATA_W-1:0] memRdData,
    output cse_pkg::cse_mem_wr_s memWr,
    output cse_pkg::cse_working_register_wr_s wregWr,
    // Sequencing
    output logic [1:0] qPhase,
    output logic busy,
    output logic nopActive,
    output logic discardFetch,
    output logic pcSkipStrobe,
    output logic [cse_pkg::WORDS_W-1:0] pcSkipWords
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic cse_pkg::cse_op_e decodeOp(input logic [cse_pkg::INSTR_W-1:0] w);
        if (w[cse_pkg::OPC7_MSB:cse_pkg::OPC7_LSB] == cse_pkg::OPC_CMP_EQ) begin
            decodeOp = cse_pkg::CSE_OP_EQ;
        end else if (w[cse_pkg::OPC7_MSB:cse_pkg::OPC7_LSB] == cse_pkg::OPC_CMP_GT) begin
            decodeOp = cse_pkg::CSE_OP_GT;
        end else if (w[cse_pkg::OPC7_MSB:cse_pkg::OPC6_LSB] == cse_pkg::OPC_COMPL) begin
            decodeOp = cse_pkg::CSE_OP_COMPL;
        end else begin
            decodeOp = cse_pkg::CSE_OP_NONE;
        end
    endfunction

    // Two-bit quarter number shown on the phase output
    function automatic logic [1:0] phaseCode(input cse_pkg::cse_phase_e p);
        phaseCode = 2'(p);
    endfunction

    cse_pkg::cse_phase_e phase;
    cse_pkg::cse_op_e curOp;
    cse_pkg::cse_op_e next_op;
    logic destFile;
    logic [cse_pkg::ADDR_W-1:0] opAddr;
    logic [cse_pkg::ADDR_W-1:0] effAddr;
    logic [cse_pkg::DATA_W-1:0] opByte;
    logic skipPending;
    logic [cse_pkg::WORDS_W-1:0] skipLeft;
    logic startOk;
    logic [cse_pkg::DATA_W:0] diff;
    logic isEqual;
    logic isGreater;
    logic skipTrue;

    assign next_op = decodeOp(instrIn.word);
    // Pending skip words refuse whatever is offered at Q1
    assign startOk = instrIn.valid && (skipLeft == cse_pkg::WORDS_NONE) && (next_op != cse_pkg::CSE_OP_NONE);

    cse_operand_addr u_addr (
        .fAddr(instrIn.word[cse_pkg::FADDR_MSB:0]),
        .bankMode(instrIn.word[cse_pkg::BANK_BIT]),
        .bankSelect(bankSelect),
        .extEnable(extEnable),
        .indexBase(indexBase),
        .effAddr(effAddr)
    );

    // ----------------------------------------------------------------
    // Compare by unsigned subtraction
    // ----------------------------------------------------------------
    assign diff = {1'b0, opByte} - {1'b0, workingReg};
    assign isEqual = (diff[cse_pkg::DATA_W-1:0] == cse_pkg::DATA_ZERO);
    // No borrow and no match means the byte is above the working register
    assign isGreater = !diff[cse_pkg::DATA_W] && !isEqual;
    assign skipTrue = ((curOp == cse_pkg::CSE_OP_EQ) && isEqual) || ((curOp == cse_pkg::CSE_OP_GT) && isGreater);

    // ----------------------------------------------------------------
    // Quarter phase sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase <= cse_pkg::CSE_PH_Q1;
            qPhase <= phaseCode(cse_pkg::CSE_PH_Q1);
        end else if (clkEn) begin
            // The phase output follows the sequencer state one for one
            case (phase)
                cse_pkg::CSE_PH_Q1: begin
                    phase <= cse_pkg::CSE_PH_Q2;
                    qPhase <= phaseCode(cse_pkg::CSE_PH_Q2);
                end
                cse_pkg::CSE_PH_Q2: begin
                    phase <= cse_pkg::CSE_PH_Q3;
                    qPhase <= phaseCode(cse_pkg::CSE_PH_Q3);
                end
                cse_pkg::CSE_PH_Q3: begin
                    phase <= cse_pkg::CSE_PH_Q4;
                    qPhase <= phaseCode(cse_pkg::CSE_PH_Q4);
                end
                default: begin
                    phase <= cse_pkg::CSE_PH_Q1;
                    qPhase <= phaseCode(cse_pkg::CSE_PH_Q1);
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Instruction capture, operand read and compare
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            curOp <= cse_pkg::CSE_OP_NONE;
            destFile <= 1'b0;
            opAddr <= cse_pkg::ADDR_ZERO;
            opByte <= cse_pkg::DATA_ZERO;
            memRd <= '0;
            busy <= 1'b0;
            skipPending <= 1'b0;
        end else if (clkEn) begin
            case (phase)
                cse_pkg::CSE_PH_Q1: begin
                    if (startOk) begin
                        curOp <= next_op;
                        destFile <= instrIn.word[cse_pkg::DEST_BIT];
                        opAddr <= effAddr;
                        memRd.en <= 1'b1;
                        memRd.addr <= effAddr;
                        busy <= 1'b1;
                    end else begin
                        curOp <= cse_pkg::CSE_OP_NONE;
                        busy <= 1'b0;
                    end
                    skipPending <= 1'b0;
                end
                cse_pkg::CSE_PH_Q2: begin
                    if (memRd.en) begin
                        opByte <= memRdData;
                    end
                    memRd.en <= 1'b0;
                end
                cse_pkg::CSE_PH_Q3: begin
                    skipPending <= skipTrue;
                end
                default: begin
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Complement result, written in Q4
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            memWr <= '0;
            wregWr <= '0;
        end else if (clkEn) begin
            // Compares never take this path, so they store nothing
            if (phase == cse_pkg::CSE_PH_Q3 && curOp == cse_pkg::CSE_OP_COMPL) begin
                memWr.en <= destFile;
                memWr.addr <= opAddr;
                memWr.data <= ~opByte;
                wregWr.en <= !destFile;
                wregWr.data <= ~opByte;
            end else begin
                memWr.en <= 1'b0;
                wregWr.en <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Skip: discard fetch, advance counter, idle cycles
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            skipLeft <= cse_pkg::WORDS_NONE;
            nopActive <= 1'b0;
            discardFetch <= 1'b0;
            pcSkipStrobe <= 1'b0;
            pcSkipWords <= cse_pkg::WORDS_NONE;
        end else if (clkEn) begin
            discardFetch <= 1'b0;
            pcSkipStrobe <= 1'b0;
            if (phase == cse_pkg::CSE_PH_Q4 && skipPending && busy) begin
                skipLeft <= nextWords;
                nopActive <= (nextWords != cse_pkg::WORDS_NONE);
                discardFetch <= 1'b1;
                pcSkipStrobe <= 1'b1;
                pcSkipWords <= nextWords;
            end else if (phase == cse_pkg::CSE_PH_Q4 && skipLeft != cse_pkg::WORDS_NONE) begin
                // Each later Q4 edge retires one discarded word
                skipLeft <= skipLeft - cse_pkg::WORDS_ONE;
                nopActive <= (skipLeft != cse_pkg::WORDS_ONE);
            end
        end
    end

endmodule

// *** verilog/cse_operand_addr.sv ***
// Effective data memory address former for byte-oriented operands
module cse_operand_addr (
    // Operand fields
    input wire logic [7:0] fAddr,
    input wire logic bankMode,
    // Core state
    input wire logic [cse_pkg::BANK_W-1:0] bankSelect,
    input wire logic extEnable,
    input wire logic [cse_pkg::ADDR_W-1:0] indexBase,
    // Result
    output logic [cse_pkg::ADDR_W-1:0] effAddr
);

    logic lowHalf;
    logic [cse_pkg::ADDR_W-1:0] indexed;

    assign lowHalf = (fAddr <= cse_pkg::ACCESS_LOW_LIMIT);
    assign indexed = indexBase + {{(cse_pkg::ADDR_W-8){1'b0}}, fAddr};

    always_comb begin
        if (bankMode) begin
            effAddr = {bankSelect, fAddr};
        end else if (extEnable && lowHalf) begin
            effAddr = indexed;
        end else if (lowHalf) begin
            effAddr = {cse_pkg::ACCESS_LOW_BANK, fAddr};
        end else begin
            effAddr = {cse_pkg::ACCESS_HIGH_BANK, fAddr};
        end
    end

endmodule

// *** verilog/cse_pkg.sv ***
// Shared constants and types for the compare-and-skip execution block
package cse_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;
    localparam int INSTR_W = 16;
    localparam int WORDS_W = 2;

    // ----------------------------------------------------------------
    // Opcode fields
    // ----------------------------------------------------------------
    localparam int OPC7_MSB = 15;
    localparam int OPC7_LSB = 9;
    localparam int OPC6_LSB = 10;
    localparam int BANK_BIT = 8;
    localparam int DEST_BIT = 9;
    localparam int FADDR_MSB = 7;
    localparam logic [6:0] OPC_CMP_EQ = 7'h31;
    localparam logic [6:0] OPC_CMP_GT = 7'h32;
    localparam logic [5:0] OPC_COMPL = 6'h07;

    // ----------------------------------------------------------------
    // Addressing
    // ----------------------------------------------------------------
    localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5F;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 12'h000;
    localparam logic [WORDS_W-1:0] WORDS_NONE = 2'h0;
    localparam logic [WORDS_W-1:0] WORDS_ONE = 2'h1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum {CSE_PH_Q1, CSE_PH_Q2, CSE_PH_Q3, CSE_PH_Q4} cse_phase_e;
    typedef enum {CSE_OP_NONE, CSE_OP_EQ, CSE_OP_GT, CSE_OP_COMPL} cse_op_e;

    typedef struct packed {
        logic valid;
        logic [INSTR_W-1:0] word;
    } cse_instr_s;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
    } cse_mem_rd_s;

    typedef struct packed {
        logic en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cse_mem_wr_s;

    typedef struct packed {
        logic en;
        logic [DATA_W-1:0] data;
    } cse_working_register_wr_s;

endpackage
